/* File: src/sam_params.svh */
// Constants for the station address and mode register bank.
// Assumes a single 125 MHz core clock and a synchronous active-high reset.
// How it works
// - Station address bits 47:32 kept in 16 bits, undefined until loaded.
// - Station address leaves the serialiser bit 0 first, bit 47 last.
// - Address and mode bits accessible only while stop or suspend is set.
// - Init routine loads mode fields from init block; host writes also accepted.
// - Bit 12 set disables link pulse monitoring; meaningful on twisted pair only.
// - Bit 11 set disables receive polarity correction; twisted pair only.
// - Bit 10 selects whether internal loopback includes the Manchester codec.
// - Bit 9 on twisted pair lowers receive threshold 4.5 dB; reset clears it.
// - Bit 9 on AUI picks transmit idle level; not under automatic selection.
// - Bits 8-7 pick port: 00 AUI, 01 twisted pair, 10 serial, 11 reserved.
// - Software port choice applies only while media-select bit is 0.
// - Reset clears threshold bit and port select, giving AUI standard settings.
// - Internal loopback bit accessible only while stop is set.
// - Retry disable gives one attempt; otherwise up to 16 attempts.
// - Loop, internal and codec bits decode into four loopback modes.
`ifndef SAM_PARAMS_SVH
`define SAM_PARAMS_SVH

`define SAM_IDX_ADDR_HI 7'h0e
`define SAM_IDX_MODE 7'h0f
`define SAM_BIT_LINK 12
`define SAM_BIT_POL 11
`define SAM_BIT_CODEC 10
`define SAM_BIT_THR 9
`define SAM_PSEL_HI 8
`define SAM_PSEL_LO 7
`define SAM_BIT_ILOOP 6
`define SAM_BIT_RETRY 5
`define SAM_MODE_MASK 16'h1fe0
`define SAM_ILOOP_MASK 16'h0040
`define SAM_MODE_RST 16'h0000
`define SAM_ADDR_RST 16'h0000
`define SAM_RDATA_ZERO 16'h0000
`define SAM_TRIES_ONE 5'h01
`define SAM_TRIES_MAX 5'h10
`define SAM_ADDR_LAST 6'h2f
`define SAM_CNT_ZERO 6'h00
`define SAM_CNT_ONE 6'h01
`define SAM_WORD_RST 48'h000000000000

`endif

/* File: src/sam_pkg.sv */
// Types shared by the station address and mode register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package sam_pkg;
    typedef enum logic [1:0] {
        SAM_PORT_AUI,
        SAM_PORT_TP,
        SAM_PORT_SERIAL,
        SAM_PORT_RSVD
    } sam_port_t;

    typedef enum logic [1:0] {
        SAM_LOOP_NONE,
        SAM_LOOP_EXT,
        SAM_LOOP_INT_CODEC,
        SAM_LOOP_INT_BYPASS
    } sam_loop_t;

    typedef enum logic {
        SAM_SH_IDLE,
        SAM_SH_RUN
    } sam_shift_state_t;
endpackage

/* File: src/sam_addr_shifter.sv */
// Serialiser that sends the 48-bit station address onto the wire side.
// Assumes start is a one-cycle pulse; starts while busy are dropped.
`include "sam_params.svh"

module sam_addr_shifter
    import sam_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [47:0] word_in,
    output logic bit_out,
    output logic valid_out
);
    sam_shift_state_t state_r;
    logic [47:0] shift_r;
    logic [5:0] cnt_r;

    // Low bit goes out first, bit 47 last
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_r <= SAM_SH_IDLE;
            shift_r <= `SAM_WORD_RST;
            cnt_r <= `SAM_CNT_ZERO;
            bit_out <= 1'b0;
            valid_out <= 1'b0;
        end else begin
            unique case (state_r)
                SAM_SH_IDLE: begin
                    if (start_in) begin
                        state_r <= SAM_SH_RUN;
                        shift_r <= word_in;
                        bit_out <= word_in[0];
                        valid_out <= 1'b1;
                        cnt_r <= `SAM_CNT_ZERO;
                    end
                end
                SAM_SH_RUN: begin
                    if (cnt_r == `SAM_ADDR_LAST) begin
                        state_r <= SAM_SH_IDLE;
                        valid_out <= 1'b0;
                        bit_out <= 1'b0;
                    end else begin
                        shift_r <= shift_r >> 1;
                        bit_out <= shift_r[1];
                        cnt_r <= cnt_r + `SAM_CNT_ONE;
                    end
                end
            endcase
        end
    end

    a_first_bit_low: assert property (@(posedge core_clk_in) disable iff (rst_in)
        start_in && state_r == SAM_SH_IDLE |=> valid_out && bit_out == $past(word_in[0]))
        else $error("address serialiser did not open with bit 0");

    a_last_bit_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
        start_in && state_r == SAM_SH_IDLE
        |=> ##47 valid_out && bit_out == $past(word_in[47], 48) ##1 !valid_out)
        else $error("address serialiser did not end with bit 47 after 48 bits");

    c_full_send: cover property (@(posedge core_clk_in) disable iff (rst_in)
        start_in && state_r == SAM_SH_IDLE ##49 !valid_out);
endmodule

/* File: src/sam_regs.sv */
// Station address high word and operating mode register bank.
// Assumes the controller core supplies stop, suspend, init-load and loop
// levels synchronous to core_clk_in, and reads the decoded mode outputs.
`include "sam_params.svh"

module sam_regs
    import sam_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [6:0] csr_index_in,
    input wire logic csr_wr_in,
    input wire logic csr_rd_in,
    input wire logic [15:0] csr_wdata_in,
    output logic [15:0] csr_rdata_out,
    output logic csr_rdata_valid_out,
    input wire logic init_load_in,
    input wire logic [15:0] init_addr_hi_in,
    input wire logic [15:0] init_mode_in,
    input wire logic stop_flag_in,
    input wire logic suspend_flag_in,
    input wire logic media_auto_in,
    input wire logic auto_port_tp_in,
    input wire logic loop_enable_in,
    input wire logic [31:0] addr_low_in,
    input wire logic addr_tx_start_in,
    output logic addr_tx_bit_out,
    output logic addr_tx_valid_out,
    output logic [15:0] station_address_hi_out,
    output logic address_loaded_out,
    output logic link_monitor_disable_out,
    output logic polarity_fix_disable_out,
    output logic codec_loopback_select_out,
    output logic low_rx_threshold_out,
    output logic aui_idle_level_select_out,
    output logic [1:0] active_port_out,
    output logic internal_loopback_out,
    output logic [1:0] loopback_mode_out,
    output logic [4:0] max_tx_attempts_out
);
    logic [15:0] addr_hi_r;
    logic [15:0] mode_r;
    logic loaded_r;
    logic access_ok;
    logic wr_addr;
    logic wr_mode;
    logic [15:0] mode_wr_nxt;
    sam_port_t port_nxt;
    sam_loop_t loop_nxt;

    // Either stop or suspend opens the bank; internal loopback wants stop alone
    assign access_ok = stop_flag_in | suspend_flag_in;
    assign wr_addr = csr_wr_in && access_ok && csr_index_in == `SAM_IDX_ADDR_HI;
    assign wr_mode = csr_wr_in && access_ok && csr_index_in == `SAM_IDX_MODE;

    // Merge of a host mode write: bit 6 keeps its value unless stopped
    always_comb begin
        mode_wr_nxt = csr_wdata_in & `SAM_MODE_MASK & ~`SAM_ILOOP_MASK;
        if (stop_flag_in) begin
            mode_wr_nxt = mode_wr_nxt | (csr_wdata_in & `SAM_ILOOP_MASK);
        end else begin
            mode_wr_nxt = mode_wr_nxt | (mode_r & `SAM_ILOOP_MASK);
        end
    end

    // Address word: init block load wins over a host write in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            addr_hi_r <= `SAM_ADDR_RST;
            loaded_r <= 1'b0;
        end else if (init_load_in) begin
            addr_hi_r <= init_addr_hi_in;
            loaded_r <= 1'b1;
        end else if (wr_addr) begin
            addr_hi_r <= csr_wdata_in;
            loaded_r <= 1'b1;
        end
    end

    // Mode word; reset clears all held bits, AUI with standard settings
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            mode_r <= `SAM_MODE_RST;
        end else if (init_load_in) begin
            mode_r <= init_mode_in & `SAM_MODE_MASK;
        end else if (wr_mode) begin
            mode_r <= mode_wr_nxt;
        end
    end

    // Register read port; locked bank reads as zero rather than stale data
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            csr_rdata_out <= `SAM_RDATA_ZERO;
            csr_rdata_valid_out <= 1'b0;
        end else begin
            csr_rdata_valid_out <= csr_rd_in;
            csr_rdata_out <= `SAM_RDATA_ZERO;
            if (csr_rd_in && access_ok) begin
                if (csr_index_in == `SAM_IDX_ADDR_HI) begin
                    csr_rdata_out <= addr_hi_r;
                end else if (csr_index_in == `SAM_IDX_MODE) begin
                    csr_rdata_out <= stop_flag_in ? mode_r : (mode_r & ~`SAM_ILOOP_MASK);
                end
            end
        end
    end

    // Port choice: software field only when media select is clear
    always_comb begin
        if (media_auto_in) begin
            port_nxt = auto_port_tp_in ? SAM_PORT_TP : SAM_PORT_AUI;
        end else begin
            port_nxt = sam_port_t'(mode_r[`SAM_PSEL_HI:`SAM_PSEL_LO]);
        end
    end

    // Loopback decode from loop, internal and codec bits
    always_comb begin
        if (!loop_enable_in) begin
            loop_nxt = SAM_LOOP_NONE;
        end else if (!mode_r[`SAM_BIT_ILOOP]) begin
            loop_nxt = SAM_LOOP_EXT;
        end else if (!mode_r[`SAM_BIT_CODEC]) begin
            loop_nxt = SAM_LOOP_INT_CODEC;
        end else begin
            loop_nxt = SAM_LOOP_INT_BYPASS;
        end
    end

    // Decoded controls, registered so the core sees clean levels
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            link_monitor_disable_out <= 1'b0;
            polarity_fix_disable_out <= 1'b0;
            codec_loopback_select_out <= 1'b0;
            low_rx_threshold_out <= 1'b0;
            aui_idle_level_select_out <= 1'b0;
            active_port_out <= SAM_PORT_AUI;
            internal_loopback_out <= 1'b0;
            loopback_mode_out <= SAM_LOOP_NONE;
            max_tx_attempts_out <= `SAM_TRIES_MAX;
        end else begin
            link_monitor_disable_out <= mode_r[`SAM_BIT_LINK] && port_nxt == SAM_PORT_TP;
            polarity_fix_disable_out <= mode_r[`SAM_BIT_POL] && port_nxt == SAM_PORT_TP;
            codec_loopback_select_out <= mode_r[`SAM_BIT_CODEC];
            low_rx_threshold_out <= mode_r[`SAM_BIT_THR] && port_nxt == SAM_PORT_TP;
            aui_idle_level_select_out <= mode_r[`SAM_BIT_THR] && port_nxt == SAM_PORT_AUI
                && !media_auto_in;
            active_port_out <= port_nxt;
            internal_loopback_out <= mode_r[`SAM_BIT_ILOOP];
            loopback_mode_out <= loop_nxt;
            max_tx_attempts_out <= mode_r[`SAM_BIT_RETRY] ? `SAM_TRIES_ONE
                : `SAM_TRIES_MAX;
        end
    end

    // Plain copies kept as flops for the output rule
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            station_address_hi_out <= `SAM_ADDR_RST;
            address_loaded_out <= 1'b0;
        end else begin
            station_address_hi_out <= addr_hi_r;
            address_loaded_out <= loaded_r;
        end
    end

    // Wire-order serialiser for the full 48-bit address
    sam_addr_shifter u_shifter (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(addr_tx_start_in),
        .word_in({addr_hi_r, addr_low_in}),
        .bit_out(addr_tx_bit_out),
        .valid_out(addr_tx_valid_out)
    );

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_locked_write_dropped: assert property (
        csr_wr_in && !stop_flag_in && !suspend_flag_in && !init_load_in
        |=> $stable(addr_hi_r) && $stable(mode_r))
        else $error("write taken while bank locked");

    a_addr_write_taken: assert property (
        wr_addr && !init_load_in |=> addr_hi_r == $past(csr_wdata_in) ##1
        station_address_hi_out == $past(csr_wdata_in, 2))
        else $error("address write not stored");

    a_iloop_suspend_only: assert property (
        wr_mode && !stop_flag_in && !init_load_in
        |=> mode_r[`SAM_BIT_ILOOP] == $past(mode_r[`SAM_BIT_ILOOP]))
        else $error("internal loopback changed without stop");

    a_init_mode_load: assert property (
        init_load_in |=> mode_r == ($past(init_mode_in) & `SAM_MODE_MASK) && loaded_r)
        else $error("init load of mode fields wrong");

    a_reset_clears_mode: assert property (
        $past(rst_in) |-> mode_r == `SAM_MODE_RST && active_port_out == SAM_PORT_AUI)
        else $error("reset did not clear mode");

    a_retry_attempts: assert property (
        ##1 max_tx_attempts_out == ($past(mode_r[`SAM_BIT_RETRY]) ? `SAM_TRIES_ONE
        : `SAM_TRIES_MAX))
        else $error("attempt limit not matching retry disable");

    a_manual_port: assert property (
        !media_auto_in |=> active_port_out == $past(mode_r[`SAM_PSEL_HI:`SAM_PSEL_LO]))
        else $error("software port choice not applied");

    a_threshold_tp_only: assert property (
        low_rx_threshold_out |-> active_port_out == SAM_PORT_TP
        && $past(mode_r[`SAM_BIT_THR]))
        else $error("low threshold outside twisted pair");

    a_aui_idle_manual: assert property (
        aui_idle_level_select_out |-> active_port_out == SAM_PORT_AUI && $past(!media_auto_in))
        else $error("idle level select under auto or non-AUI");

    a_link_pol_tp: assert property (
        (link_monitor_disable_out || polarity_fix_disable_out)
        |-> active_port_out == SAM_PORT_TP)
        else $error("twisted pair control active on other port");

    a_loop_bypass: assert property (
        loopback_mode_out == SAM_LOOP_INT_BYPASS
        |-> $past(loop_enable_in && mode_r[`SAM_BIT_ILOOP] && mode_r[`SAM_BIT_CODEC]))
        else $error("codec bypass loopback without all three bits");

    c_suspend_write: cover property (wr_mode && !stop_flag_in ##1 !init_load_in);
    c_bypass_loop: cover property (loopback_mode_out == SAM_LOOP_INT_BYPASS);
    c_auto_tp: cover property (media_auto_in && auto_port_tp_in ##1
        active_port_out == SAM_PORT_TP);
    c_init_then_read: cover property (init_load_in ##1 csr_rd_in && access_ok);
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the station address and mode register bank.
// Assumes sam_pkg, sam_addr_shifter and sam_regs are compiled first.
`include "sam_params.svh"

module tb
    import sam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, rst, csr_wr, csr_rd, init_load, stop_flag, suspend_flag;
    logic media_auto, auto_port_tp, loop_enable, addr_tx_start;
    logic [6:0] csr_index;
    logic [15:0] csr_wdata, init_addr_hi, init_mode;
    logic [31:0] addr_low;
    logic [15:0] csr_rdata, station_address_hi;
    logic csr_rdata_valid, addr_tx_bit, addr_tx_valid, address_loaded;
    logic link_monitor_disable, polarity_fix_disable, codec_loopback_select;
    logic low_rx_threshold, aui_idle_level_select, internal_loopback;
    logic [1:0] active_port, loopback_mode;
    logic [4:0] max_tx_attempts;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;

    sam_regs u_dut (.core_clk_in(core_clk), .rst_in(rst), .csr_index_in(csr_index),
        .csr_wr_in(csr_wr), .csr_rd_in(csr_rd), .csr_wdata_in(csr_wdata),
        .csr_rdata_out(csr_rdata), .csr_rdata_valid_out(csr_rdata_valid),
        .init_load_in(init_load), .init_addr_hi_in(init_addr_hi), .init_mode_in(init_mode),
        .stop_flag_in(stop_flag), .suspend_flag_in(suspend_flag), .media_auto_in(media_auto),
        .auto_port_tp_in(auto_port_tp), .loop_enable_in(loop_enable), .addr_low_in(addr_low),
        .addr_tx_start_in(addr_tx_start), .addr_tx_bit_out(addr_tx_bit),
        .addr_tx_valid_out(addr_tx_valid), .station_address_hi_out(station_address_hi),
        .address_loaded_out(address_loaded), .link_monitor_disable_out(link_monitor_disable),
        .polarity_fix_disable_out(polarity_fix_disable),
        .codec_loopback_select_out(codec_loopback_select),
        .low_rx_threshold_out(low_rx_threshold),
        .aui_idle_level_select_out(aui_idle_level_select), .active_port_out(active_port),
        .internal_loopback_out(internal_loopback), .loopback_mode_out(loopback_mode),
        .max_tx_attempts_out(max_tx_attempts));

    // 125 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Ceiling well above the couple of hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    // Strobes are dropped on the edge that takes them, so tasks may run back to back
    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        @(posedge core_clk);
        csr_index <= idx;
        csr_wdata <= d;
        csr_wr <= 1'b1;
        @(posedge core_clk);
        csr_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [6:0] idx, input logic [15:0] exp);
        @(posedge core_clk);
        csr_index <= idx;
        csr_rd <= 1'b1;
        @(posedge core_clk);
        csr_rd <= 1'b0;
        #1;
        chk(16'(csr_rdata_valid), 16'h0001, "read valid");
        chk(csr_rdata, exp, "read data");
    endtask

    // Derived outputs lag stored state and levels by one cycle
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic flags(input logic st, input logic sp);
        @(posedge core_clk);
        stop_flag <= st;
        suspend_flag <= sp;
    endtask

    task automatic pulse_init(input logic [15:0] a, input logic [15:0] m);
        @(posedge core_clk);
        init_addr_hi <= a;
        init_mode <= m;
        init_load <= 1'b1;
        @(posedge core_clk);
        init_load <= 1'b0;
        settle();
    endtask

    task automatic t_reset_vals();
        #1;
        chk(16'(active_port), 16'h0000, "port after reset");
        chk(16'(max_tx_attempts), 16'h0010, "attempts after reset");
        chk(16'(address_loaded), 16'h0000, "loaded after reset");
        chk(16'(low_rx_threshold), 16'h0000, "threshold after reset");
        flags(1'b1, 1'b0);
        rdchk(`SAM_IDX_MODE, 16'h0000);
        $display("test reset_vals done");
    endtask

    task automatic t_host_mode();
        wr(`SAM_IDX_MODE, 16'hffff);
        rdchk(`SAM_IDX_MODE, 16'h1fe0);
        wr(`SAM_IDX_MODE, 16'h1aa0);
        settle();
        chk(16'(link_monitor_disable), 16'h0001, "link off");
        chk(16'(polarity_fix_disable), 16'h0001, "polarity off");
        chk(16'(low_rx_threshold), 16'h0001, "low threshold");
        chk(16'(max_tx_attempts), 16'h0001, "one attempt");
        wr(`SAM_IDX_MODE, 16'h0080);
        settle();
        chk(16'(link_monitor_disable), 16'h0000, "link on");
        chk(16'(polarity_fix_disable), 16'h0000, "polarity on");
        chk(16'(low_rx_threshold), 16'h0000, "std threshold");
        chk(16'(max_tx_attempts), 16'h0010, "sixteen attempts");
        $display("test host_mode done");
    endtask

    task automatic t_ports();
        for (int p = 0; p < 4; p++) begin
            wr(`SAM_IDX_MODE, 16'(p << 7) | 16'h0200);
            settle();
            chk(16'(active_port), 16'(p), "port select");
            chk(16'(aui_idle_level_select), 16'(p == 0), "idle level");
            chk(16'(low_rx_threshold), 16'(p == 1), "threshold by port");
        end
        // Automatic selection overrides the software field
        @(posedge core_clk);
        media_auto <= 1'b1;
        auto_port_tp <= 1'b0;
        wr(`SAM_IDX_MODE, 16'h0280);
        settle();
        chk(16'(active_port), 16'h0000, "auto aui");
        chk(16'(aui_idle_level_select), 16'h0000, "no idle under auto");
        @(posedge core_clk);
        auto_port_tp <= 1'b1;
        settle();
        chk(16'(active_port), 16'h0001, "auto tp");
        chk(16'(low_rx_threshold), 16'h0001, "auto tp threshold");
        @(posedge core_clk);
        media_auto <= 1'b0;
        $display("test ports done");
    endtask

    task automatic t_locks();
        wr(`SAM_IDX_MODE, 16'h0040);
        flags(1'b0, 1'b1);
        rdchk(`SAM_IDX_MODE, 16'h0000);
        wr(`SAM_IDX_MODE, 16'h0020);
        wr(`SAM_IDX_ADDR_HI, 16'h1234);
        rdchk(`SAM_IDX_ADDR_HI, 16'h1234);
        settle();
        chk(16'(internal_loopback), 16'h0001, "loopback kept");
        flags(1'b0, 1'b0);
        wr(`SAM_IDX_MODE, 16'h1000);
        wr(`SAM_IDX_ADDR_HI, 16'hbeef);
        rdchk(`SAM_IDX_ADDR_HI, 16'h0000);
        flags(1'b1, 1'b0);
        rdchk(`SAM_IDX_MODE, 16'h0060);
        rdchk(`SAM_IDX_ADDR_HI, 16'h1234);
        rdchk(7'h10, 16'h0000);
        $display("test locks done");
    endtask

    task automatic t_loop();
        logic [1:0] exp;
        for (int i = 0; i < 8; i++) begin
            wr(`SAM_IDX_MODE, (i[1] ? 16'h0040 : 16'h0000) | (i[0] ? 16'h0400 : 16'h0000));
            loop_enable <= i[2];
            settle();
            exp = !i[2] ? 2'h0 : (!i[1] ? 2'h1 : (i[0] ? 2'h3 : 2'h2));
            chk(16'(loopback_mode), 16'(exp), "loop mode");
            chk(16'(codec_loopback_select), 16'(i[0]), "codec select");
            chk(16'(internal_loopback), 16'(i[1]), "internal flag");
        end
        loop_enable <= 1'b0;
        $display("test loop done");
    endtask

    task automatic t_init_shift();
        flags(1'b0, 1'b0);
        pulse_init(16'ha5c3, 16'hffff);
        chk(station_address_hi, 16'ha5c3, "init address");
        chk(16'(address_loaded), 16'h0001, "loaded");
        chk(16'(max_tx_attempts), 16'h0001, "init retry bit");
        flags(1'b1, 1'b0);
        rdchk(`SAM_IDX_MODE, 16'h1fe0);
        @(posedge core_clk);
        addr_tx_start <= 1'b1;
        @(posedge core_clk);
        addr_tx_start <= 1'b0;
        for (int k = 0; k < 48; k++) begin
            #1;
            chk(16'(addr_tx_valid), 16'h0001, "send valid");
            chk(16'(addr_tx_bit), 16'({16'ha5c3, 32'h12345678} >> k) & 16'h0001, "bit");
            @(posedge core_clk);
        end
        #1;
        chk(16'(addr_tx_valid), 16'h0000, "send over");
        $display("test init_shift done");
    endtask

    task automatic t_rereset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        chk(16'(active_port), 16'h0000, "port cleared");
        chk(16'(aui_idle_level_select), 16'h0000, "idle cleared");
        chk(16'(low_rx_threshold), 16'h0000, "threshold cleared");
        chk(16'(address_loaded), 16'h0000, "address undefined");
        rdchk(`SAM_IDX_MODE, 16'h0000);
        $display("test rereset done");
    endtask

    // Every input gets a value at time zero; reset held ten cycles
    initial begin
        rst = 1'b1;
        {csr_wr, csr_rd, init_load, stop_flag, suspend_flag} = 5'h00;
        {media_auto, auto_port_tp, loop_enable, addr_tx_start} = 4'h0;
        csr_index = 7'h00;
        csr_wdata = 16'h0000;
        init_addr_hi = 16'h0000;
        init_mode = 16'h0000;
        addr_low = 32'h12345678;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_vals();
        t_host_mode();
        t_ports();
        t_locks();
        t_loop();
        t_init_shift();
        t_rereset();
        summarize();
    end
endmodule
